// ### ees_regs.vh
// constants for the two-wire nonvolatile memory slave
`ifndef EES_REGS_VH
`define EES_REGS_VH
// fixed device type group of the address byte; the value is arbitrary
`define EES_DEV_TYPE 4'hc
`define EES_DIR_BIT 0
`define EES_ADDR_W 7
`define EES_COL_W 3
`define EES_MEM_WORDS 128
`define EES_PAGE_BYTES 8
`define EES_CLK_HZ 40000000
`define EES_TWR_MS 6
`define EES_TWR_CYC ((`EES_CLK_HZ / 1000) * `EES_TWR_MS)
`define EES_ERASED_BYTE 8'hff
`endif

// ### ees_slave.v
// two-wire serial slave front end of a 128-byte nonvolatile memory with page writes
`timescale 1ns/100ps
// notes for whoever integrates this block:
// - every pin passes two flops before it is looked at, so each phase
//   of the bus clock must last at least four core_clk cycles
// - the data line is open drain: sda_oe_n low pulls the line low and
//   sda_out is then always low; a one bit is sent by letting go
// - read data changes about three cycles after the clock falls, well
//   inside the low phase, so the line never moves while clock is high
// - the fall of the clock that closes a start is not a data bit; the
//   bit counter is parked one below zero until that fall
// - the array is a plain register file: a commit at stop is instant and
//   write_busy only models the programming time seen from the bus
// - the busy timer is a separate process so that a long count never
//   sits on the path of the bit sequencer
// - a repeated start keeps the pointer, so a random read is a dummy
//   write of the word address followed by a read address byte
// - a stop outside the data phase programs nothing, and a byte cut off
//   by a stop never reaches the page buffer
// - during a write only the column bits of the pointer move, so the
//   pointer stays inside the row it was given
// - the memory is not cleared by resetn, it comes up erased
// - an address byte that does not match, or arrives while busy, parks
//   the sequencer until the next start
`include "ees_regs.vh"
module ees_slave #(
  parameter TWR_CYCLES = `EES_TWR_CYC
) (
  input wire core_clk,
  input wire resetn,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n,
  input wire addr_select_pin_0,
  input wire addr_select_pin_1,
  input wire addr_select_pin_2,
  output reg write_busy
);
  localparam ST_IDLE = 3'd0;
  localparam ST_DEVADDR = 3'd1;
  localparam ST_WORDADDR = 3'd2;
  localparam ST_WDATA = 3'd3;
  localparam ST_RDATA = 3'd4;

  integer j;

  // ************************************************
  // pin synchronisers
  // ************************************************
  reg [1:0] scl_s_q;
  reg [1:0] sda_s_q;
  reg [1:0] pin_s0_q;
  reg [1:0] pin_s1_q;
  reg [1:0] pin_s2_q;
  reg scl_d1_q;
  reg sda_d1_q;
  // idle bus reads high out of reset
  // two stages before any logic; stage 0 feeds only stage 1
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      pin_s0_q <= 2'h0;
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], scl_in};
      sda_s_q <= {sda_s_q[0], sda_in};
      pin_s0_q <= {pin_s0_q[0], addr_select_pin_0};
      pin_s1_q <= {pin_s1_q[0], addr_select_pin_1};
      pin_s2_q <= {pin_s2_q[0], addr_select_pin_2};
      scl_d1_q <= scl_s_q[1];
      sda_d1_q <= sda_s_q[1];
    end
  end

  wire scl_v = scl_s_q[1];
  wire sda_v = sda_s_q[1];
  wire scl_rise = scl_v & ~scl_d1_q;
  wire scl_fall = ~scl_v & scl_d1_q;
  wire start_det = scl_v & scl_d1_q & sda_d1_q & ~sda_v;
  wire stop_det = scl_v & scl_d1_q & ~sda_d1_q & sda_v;
  wire [2:0] pins = {pin_s2_q[1], pin_s1_q[1], pin_s0_q[1]};

  // ************************************************
  // protocol state
  // ************************************************
  reg [2:0] state_q;
  reg [3:0] bit_q;          // 0..7 data bits, 8 is the acknowledge slot
  reg [7:0] shift_q;
  reg [7:0] tx_q;
  reg [`EES_ADDR_W-1:0] ptr_q;
  reg ack_q;                // we own the acknowledge slot
  reg nack_q;               // master refused the last byte read
  reg [7:0] page_q [0:`EES_PAGE_BYTES-1];
  reg [`EES_PAGE_BYTES-1:0] page_vld_q;
  reg [`EES_ADDR_W-`EES_COL_W-1:0] row_q;
  reg [7:0] mem_q [0:`EES_MEM_WORDS-1];
  reg [31:0] twr_cnt_q;
  reg commit_q;             // one-cycle request to the write timer
  integer i;

  wire [`EES_COL_W-1:0] col = ptr_q[`EES_COL_W-1:0];
  wire [`EES_ADDR_W-1:0] ptr_inc = ptr_q + 1'b1;
  // byte under the pointer, sent msb first on reads
  wire [7:0] rd_byte = mem_q[ptr_q];
  wire [`EES_COL_W-1:0] col_inc = col + 1'b1;
  wire addr_hit = (shift_q[7:4] == `EES_DEV_TYPE) && (shift_q[3:1] == pins);

  // ************************************************
  // main sequencer, steps on synchronised clock edges
  // ************************************************
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= {`EES_ADDR_W{1'b0}};
      ack_q <= 1'b0;
      nack_q <= 1'b0;
      page_vld_q <= {`EES_PAGE_BYTES{1'b0}};
      row_q <= {(`EES_ADDR_W-`EES_COL_W){1'b0}};
      commit_q <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      commit_q <= 1'b0;
      if (start_det) begin
        // first byte is the address; repeated start keeps pointer
        state_q <= ST_DEVADDR;
        // the clock fall that closes the start brings this to zero
        bit_q <= 4'hf;
        ack_q <= 1'b0;
        sda_oe_n <= 1'b1;
      end else if (stop_det) begin
        state_q <= ST_IDLE;
        sda_oe_n <= 1'b1;
        // program only at stop; only acknowledged bytes
        if (state_q == ST_WDATA && page_vld_q != {`EES_PAGE_BYTES{1'b0}}) begin
          for (i = 0; i < `EES_PAGE_BYTES; i = i + 1) begin
            if (page_vld_q[i]) begin
              mem_q[{row_q, i[`EES_COL_W-1:0]}] <= page_q[i];
            end
          end
          commit_q <= 1'b1;
        end
        page_vld_q <= {`EES_PAGE_BYTES{1'b0}};
      end else if (state_q != ST_IDLE) begin
        if (scl_rise && bit_q < 4'h8) begin
          shift_q <= {shift_q[6:0], sda_v};
        end
        if (scl_rise && bit_q == 4'h8 && state_q == ST_RDATA) begin
          nack_q <= sda_v;
        end
        // eight bits then the acknowledge slot
        if (scl_fall) begin
          if (bit_q == 4'h7) begin
            bit_q <= 4'h8;
            sda_oe_n <= 1'b1;
            case (state_q)
              ST_DEVADDR: begin
                // wrong address or busy: no ack, idle until start
                if (addr_hit && !write_busy) begin
                  ack_q <= 1'b1;
                  sda_out <= 1'b0;
                  sda_oe_n <= 1'b0;
                end else begin
                  state_q <= ST_IDLE;
                end
              end
              ST_WORDADDR: begin
                ptr_q <= shift_q[`EES_ADDR_W-1:0];
                row_q <= shift_q[`EES_ADDR_W-1:`EES_COL_W];
                sda_out <= 1'b0;
                sda_oe_n <= 1'b0;
              end
              ST_WDATA: begin
                page_q[col] <= shift_q;
                page_vld_q[col] <= 1'b1;
                ptr_q <= {row_q, col_inc};
                sda_out <= 1'b0;
                sda_oe_n <= 1'b0;
              end
              default: begin
                // pointer advances after each byte sent
                ptr_q <= ptr_inc;
              end
            endcase
          end else if (bit_q == 4'h8) begin
            bit_q <= 4'h0;
            sda_oe_n <= 1'b1;
            case (state_q)
              ST_DEVADDR: begin
                if (shift_q[`EES_DIR_BIT]) begin
                  state_q <= ST_RDATA;
                  // pointer may sit back at column zero of its row after a write wrap
                  tx_q <= {rd_byte[6:0], 1'b0};
                  sda_out <= rd_byte[7];
                  sda_oe_n <= rd_byte[7];
                end else begin
                  state_q <= ST_WORDADDR;
                end
              end
              ST_WORDADDR: state_q <= ST_WDATA;
              ST_WDATA: state_q <= ST_WDATA;
              default: begin
                // master refused: release and wait for stop
                if (nack_q) begin
                  state_q <= ST_IDLE;
                end else begin
                  tx_q <= {rd_byte[6:0], 1'b0};
                  sda_out <= rd_byte[7];
                  sda_oe_n <= rd_byte[7];
                end
              end
            endcase
          end else begin
            bit_q <= bit_q + 4'h1;
            if (state_q == ST_RDATA) begin
              sda_out <= tx_q[7];
              sda_oe_n <= tx_q[7];
              tx_q <= {tx_q[6:0], 1'b0};
            end
          end
        end
      end
    end
  end


  // ************************************************
  // self-timed write timer
  // ************************************************
  // busy for the whole programming time; the count is only
  // timing, the array already holds the new bytes
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      twr_cnt_q <= 32'h0;
      write_busy <= 1'b0;
    end else if (commit_q) begin
      twr_cnt_q <= TWR_CYCLES - 1;
      write_busy <= 1'b1;
    end else if (write_busy) begin
      if (twr_cnt_q == 32'h0) begin
        write_busy <= 1'b0;
      end else begin
        twr_cnt_q <= twr_cnt_q - 32'h1;
      end
    end
  end

  // ************************************************
  // erased contents at power up
  // ************************************************
  // own loop variable so the sequencer's index has a single driver
  initial begin
    for (j = 0; j < `EES_MEM_WORDS; j = j + 1) begin
      mem_q[j] = `EES_ERASED_BYTE;
    end
    for (j = 0; j < `EES_PAGE_BYTES; j = j + 1) begin
      page_q[j] = 8'h00;
    end
  end
endmodule

// ### ees_slave_sva.sv
// assertion checker on the memory slave ports
`timescale 1ns/100ps
module ees_slave_sva #(
  parameter TWR_CYCLES = 240000
) (
  input wire core_clk,
  input wire resetn,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe_n,
  input wire addr_select_pin_0,
  input wire addr_select_pin_1,
  input wire addr_select_pin_2,
  input wire write_busy
);
  logic [31:0] busy_cnt_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // busy length counter, a plain repeat would be far too long
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      busy_cnt_q <= 32'h0;
    else
      busy_cnt_q <= write_busy ? busy_cnt_q + 32'h1 : 32'h0;
  end
  chk_reset_quiet: assert property ($rose(resetn) |-> sda_oe_n && !write_busy)
    else $error("outputs active after reset");
  chk_drive_clk_low: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("drive changed with clock high");
  chk_ack_hold: assert property ($fell(sda_oe_n) |=> !sda_oe_n [*4])
    else $error("drive released too early");
  chk_drive_low: assert property (!sda_oe_n |-> !sda_out)
    else $error("driving a high level");
  chk_busy_length: assert property ($fell(write_busy) |-> busy_cnt_q == TWR_CYCLES)
    else $error("busy length wrong");
  chk_busy_at_stop: assert property ($rose(write_busy) |-> scl_in && sda_in)
    else $error("busy without stop");
  chk_busy_no_ack: assert property (write_busy |-> sda_oe_n)
    else $error("drive while busy");
  chk_stop_released: assert property (scl_in && $rose(sda_in) |-> sda_oe_n [*3])
    else $error("drive after stop");
  cov_write: cover property ($rose(write_busy));
  cov_drive: cover property ($fell(sda_oe_n));
  cov_stop: cover property (scl_in && $rose(sda_in));
endmodule
bind ees_slave ees_slave_sva #(.TWR_CYCLES(TWR_CYCLES)) i_chk (.*);

// ### ees_mst.sv
// behavioural bus master on the serial clock and data lines
`timescale 1ns/100ps
module ees_mst (
  output reg scl,
  output reg sda_m,
  input wire sda
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task bitx(input v, output s);
    begin
      #50 sda_m = v;
      #50 scl = 1'b1;
      #90 s = sda;
      #10 scl = 1'b0;
    end
  endtask
  task start;
    begin
      #100 sda_m = 1'b0;
      #100 scl = 1'b0;
    end
  endtask
  task rstart;
    begin
      #50 sda_m = 1'b1;
      #50 scl = 1'b1;
      start;
    end
  endtask
  // data rises clock high; clock then stands still
  task stop;
    begin
      #50 sda_m = 1'b0;
      #50 scl = 1'b1;
      #100 sda_m = 1'b1;
      #200;
    end
  endtask
  task sendb(input [7:0] b, output a);
    integer i;
    reg s;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bitx(b[i], s);
      bitx(1'b1, a);
    end
  endtask
  task recvb(input nak, output [7:0] b, output r);
    integer i;
    reg s;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bitx(1'b1, s);
        b[i] = s;
      end
      bitx(nak, r);
    end
  endtask
endmodule

// ### tb_i2c_eeprom_page_write_slave.sv
// self-checking bench for the memory slave
`timescale 1ns/100ps
`include "ees_regs.vh"
module tb_i2c_eeprom_page_write_slave;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] pins = 3'h5;
  wire scl;
  wire sda_m;
  wire sda_out;
  wire sda_oe_n;
  wire write_busy;
  // open-drain line, pulled up when nobody pulls low
  wire sda = sda_m & sda_oe_n;
  integer n_fail = 0;
  integer n_compared = 0;
  always #12.5 core_clk = ~core_clk;
  ees_mst i_mst (.scl(scl), .sda_m(sda_m), .sda(sda));
  ees_slave #(.TWR_CYCLES(400)) i_dut (.core_clk(core_clk), .resetn(resetn), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_select_pin_0(pins[0]), .addr_select_pin_1(pins[1]),
    .addr_select_pin_2(pins[2]), .write_busy(write_busy));
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        n_fail = n_fail + 1;
      end
    end
  endtask
  task test_done;
    begin
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // send a byte and compare the acknowledge level
  task sendc(input [7:0] b, input e);
    reg a;
    begin
      i_mst.sendb(b, a);
      chk({7'h0, a}, {7'h0, e});
    end
  endtask
  // wrong select pins or device type: no answer at all
  task t_mismatch;
    begin
      i_mst.start;
      sendc({`EES_DEV_TYPE, ~pins, 1'b0}, 1'b1);
      sendc(8'h00, 1'b1);
      i_mst.stop;
      i_mst.start;
      sendc({4'h5, pins, 1'b0}, 1'b1);
      i_mst.stop;
    end
  endtask
  // three bytes from column 6 wrap in the row; a cut byte is dropped
  task t_write;
    reg r;
    integer i;
    begin
      i_mst.start;
      sendc({`EES_DEV_TYPE, pins, 1'b0}, 1'b0);
      sendc(8'h0e, 1'b0);
      for (i = 0; i < 3; i = i + 1)
        sendc(8'ha0 + i[7:0], 1'b0);
      i_mst.bitx(1'b0, r);
      i_mst.bitx(1'b1, r);
      chk({7'h0, write_busy}, 8'h0);
      i_mst.stop;
      chk({7'h0, write_busy}, 8'h1);
      i_mst.start;
      sendc({`EES_DEV_TYPE, pins, 1'b0}, 1'b1);
      i_mst.stop;
      for (i = 0; i < 600 && write_busy !== 1'b0; i = i + 1) begin
        @(posedge core_clk);
        #2;
      end
      if (write_busy !== 1'b0) begin
        chk({7'h0, write_busy}, 8'h0);
        test_done;
      end
    end
  endtask
  // a whole row from column zero, then a current read at the wrapped pointer
  task t_row;
    reg [7:0] b;
    reg r;
    integer i;
    begin
      i_mst.start;
      sendc({`EES_DEV_TYPE, pins, 1'b0}, 1'b0);
      sendc(8'h18, 1'b0);
      for (i = 0; i < 8; i = i + 1)
        sendc(8'h30 + i[7:0], 1'b0);
      i_mst.stop;
      for (i = 0; i < 600 && write_busy !== 1'b0; i = i + 1) begin
        @(posedge core_clk);
        #2;
      end
      chk({7'h0, write_busy}, 8'h0);
      if (write_busy !== 1'b0)
        test_done;
      i_mst.start;
      sendc({`EES_DEV_TYPE, pins, 1'b1}, 1'b0);
      i_mst.recvb(1'b1, b, r);
      chk(b, 8'h30);
      i_mst.stop;
      rd(8'h1e, 8'h36, 8'h37);
    end
  endtask
  // random read of two bytes, master refuses the second
  task rd(input [7:0] wa, input [7:0] e0, input [7:0] e1);
    reg [7:0] b;
    reg r;
    begin
      i_mst.start;
      sendc({`EES_DEV_TYPE, pins, 1'b0}, 1'b0);
      sendc(wa, 1'b0);
      i_mst.rstart;
      sendc({`EES_DEV_TYPE, pins, 1'b1}, 1'b0);
      i_mst.recvb(1'b0, b, r);
      chk(b, e0);
      i_mst.recvb(1'b1, b, r);
      chk(b, e1);
      chk({7'h0, r}, 8'h1);
      i_mst.stop;
    end
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    #2 resetn = 1'b1;
    repeat (4) @(posedge core_clk);
    #2;
    t_mismatch;
    t_write;
    rd(8'h0e, 8'ha0, 8'ha1);
    rd(8'h0f, 8'ha1, `EES_ERASED_BYTE);
    rd(8'h08, 8'ha2, `EES_ERASED_BYTE);
    t_row;
    test_done;
  end
endmodule
